// *** msac_device.sv ***
// Converter chip end: channel latch, start handling, SAR sequencing, outputs
`timescale 1ns/1ns
`include "msac_map.svh"
module msac_device (
    input  wire logic                    clk_i,        // System clock
    input  wire logic                    rst_i,        // Sync reset, high
    msac_link_if.dev                     link,         // Pins to controller
    input  wire logic                    cmp_i,        // Comparator: in >= trial
    output logic [15:0]                  channel_on_o, // Channel switches
    output msac_pkg::msac_result_t       dac_code_o    // Ladder trial code
);
    import msac_pkg::*;

    // Pin vector positions
    localparam int P_CK  = 0;
    localparam int P_STB = 1;
    localparam int P_MUX = 2;
    localparam int P_ST  = 3;
    localparam int P_DRV = 4;
    localparam int P_W1  = 5;
    localparam int P_W2  = 6;
    localparam int P_W4  = 7;
    localparam int P_W8  = 8;
    localparam int P_CMP = 9;

    // One-hot channel decode, code zero picks the first channel
    function automatic logic [15:0] chan_decode(input logic [3:0] code);
        logic [15:0] hot;
        hot       = 16'h0000;
        hot[code] = 1'b1;
        return hot;
    endfunction

    // Bit position under test for a given conversion tick
    function automatic logic [2:0] bit_under_test(input logic [5:0] tick);
        return 3'h7 - tick[5:3];
    endfunction

    logic [9:0]           pin_meta_reg;
    logic [9:0]           pin_sync_reg;
    logic [9:0]           pin_prev_reg;
    logic [9:0]           pin_raw;
    msac_dev_state_t      state_reg;
    msac_dev_state_t      state_next;
    logic [3:0]           chan_reg;
    logic [15:0]          chan_on_reg;
    logic [5:0]           tick_reg;
    msac_result_t         sar_reg;
    msac_result_t         sar_next;
    msac_result_t         result_reg;
    logic                 done_reg;
    logic                 drop_pend_reg;
    logic                 oe_reg;

    assign pin_raw = {cmp_i,
                      link.channel_select_w8,
                      link.channel_select_w4,
                      link.channel_select_w2,
                      link.channel_select_w1,
                      link.result_drive,
                      link.start_conv,
                      link.mux_connect,
                      link.chan_strobe,
                      link.conv_clk};

    // Edge detection works on the second synchroniser stage only
    wire       ck_rise    = pin_sync_reg[P_CK] & ~pin_prev_reg[P_CK];
    wire       stb_rise   = pin_sync_reg[P_STB] & ~pin_prev_reg[P_STB];
    wire       st_rise    = pin_sync_reg[P_ST] & ~pin_prev_reg[P_ST];
    wire       st_fall    = ~pin_sync_reg[P_ST] & pin_prev_reg[P_ST];
    wire [3:0] sel_code   = {pin_sync_reg[P_W8], pin_sync_reg[P_W4],
                             pin_sync_reg[P_W2], pin_sync_reg[P_W1]};
    wire [2:0] bit_idx    = bit_under_test(tick_reg);
    wire       slot_first = (tick_reg[2:0] == 3'h0);
    wire       slot_last  = (tick_reg[2:0] == 3'h7);
    wire       conv_last  = (tick_reg == `MSAC_CONV_TICKS);
    wire       conv_step  = (state_reg == DS_CONV) && ck_rise;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_reg <= 10'h000;
            pin_sync_reg <= 10'h000;
            pin_prev_reg <= 10'h000;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Channel latch and switch drive
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chan_reg    <= 4'h0;
            chan_on_reg <= 16'h0000;
        end
        else
        begin
            if (stb_rise)
            begin
                chan_reg <= sel_code;
            end
            if (pin_sync_reg[P_MUX])
            begin
                chan_on_reg <= chan_decode(chan_reg);
            end
            else
            begin
                chan_on_reg <= 16'h0000;
            end
        end
    end

    // Sequencing: a trigger rise always wins, even mid-conversion
    always_comb
    begin
        state_next = state_reg;
        if (st_rise)
        begin
            state_next = DS_CLEAR;
        end
        else if (state_reg == DS_CLEAR && st_fall)
        begin
            state_next = DS_CONV;
        end
        else if (conv_step && conv_last)
        begin
            state_next = DS_IDLE;
        end
    end

    // Successive approximation: set trial bit, keep it if comparator agrees
    always_comb
    begin
        sar_next = sar_reg;
        if (st_rise)
        begin
            sar_next = 8'h00;
        end
        else if (conv_step && slot_first)
        begin
            sar_next[bit_idx] = 1'b1;
        end
        else if (conv_step && slot_last)
        begin
            sar_next[bit_idx] = pin_sync_reg[P_CMP];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= DS_IDLE;
            sar_reg   <= 8'h00;
            tick_reg  <= 6'h00;
        end
        else
        begin
            state_reg <= state_next;
            sar_reg   <= sar_next;
            if (state_reg != DS_CONV)
            begin
                tick_reg <= 6'h00;
            end
            else if (ck_rise)
            begin
                tick_reg <= tick_reg + 6'h01;
            end
        end
    end

    // Done flag and result latch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_reg      <= 1'b1;
            drop_pend_reg <= 1'b0;
            result_reg    <= 8'h00;
        end
        else
        begin
            if (st_rise)
            begin
                drop_pend_reg <= 1'b1;
            end
            else if (drop_pend_reg && ck_rise)
            begin
                drop_pend_reg <= 1'b0;
            end
            if (drop_pend_reg && ck_rise && !st_rise)
            begin
                done_reg <= 1'b0;
            end
            else if (conv_step && conv_last && !st_rise)
            begin
                done_reg   <= 1'b1;
                result_reg <= sar_next;
            end
        end
    end

    // Result drive follows the drive input
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oe_reg <= 1'b0;
        end
        else
        begin
            oe_reg <= pin_sync_reg[P_DRV];
        end
    end

    assign link.conv_done = done_reg;
    assign link.data_out  = result_reg;
    assign link.data_oe   = oe_reg;
    assign channel_on_o   = chan_on_reg;
    assign dac_code_o     = sar_reg;

endmodule

// *** msac_map.svh ***
// Constants for the multiplexed SAR converter control: timing, offsets, fields
`ifndef MSAC_MAP_SVH
`define MSAC_MAP_SVH

// System clock rate and timing figures in their own units
`define MSAC_CLK_MHZ        100
`define MSAC_SETTLE_NS      2500
`define MSAC_START_NS       200
`define MSAC_ADDR_HOLD_NS   50
// Least times round up to whole system clock cycles
`define MSAC_SETTLE_CYC     ((`MSAC_SETTLE_NS * `MSAC_CLK_MHZ + 999) / 1000)
`define MSAC_START_CYC      ((`MSAC_START_NS * `MSAC_CLK_MHZ + 999) / 1000)
`define MSAC_ADDR_HOLD_CYC  ((`MSAC_ADDR_HOLD_NS * `MSAC_CLK_MHZ + 999) / 1000)

// Conversion clock: half period in system cycles (625 kHz)
`define MSAC_CONV_HALF      16'h0050
// Last tick of a conversion and number of result bits
`define MSAC_CONV_TICKS     6'h3F
`define MSAC_RESULT_BITS    8
// System cycles the result bus is driven before it is sampled
`define MSAC_READ_WAIT      16'h0006

// Register byte offsets on the controller's Wishbone port
`define MSAC_REG_CTRL       8'h00
`define MSAC_REG_STATUS     8'h04
`define MSAC_REG_IRQ_STAT   8'h08
`define MSAC_REG_IRQ_MASK   8'h0C

// Field positions
`define MSAC_CTRL_CH_LSB    0
`define MSAC_CTRL_MUX       4
`define MSAC_CTRL_FREE      5
`define MSAC_CTRL_GO        8
`define MSAC_STAT_BUSY      0
`define MSAC_STAT_DONE      1
`define MSAC_STAT_RES_LSB   8
`define MSAC_IRQ_DONE       0

// Reset values
`define MSAC_CTRL_RST       6'h10
`define MSAC_MASK_RST       1'h0

`endif

// *** msac_pkg.sv ***
// Types shared by both ends of the converter link
package msac_pkg;

    typedef enum logic [1:0] {
        DS_IDLE  = 2'b00,
        DS_CLEAR = 2'b01,
        DS_CONV  = 2'b10
    } msac_dev_state_t;

    typedef enum logic [2:0] {
        CS_IDLE   = 3'b000,
        CS_SETUP  = 3'b001,
        CS_STROBE = 3'b010,
        CS_START  = 3'b011,
        CS_LOW    = 3'b100,
        CS_HIGH   = 3'b101,
        CS_READ   = 3'b110
    } msac_ctl_state_t;

    typedef logic [7:0] msac_result_t;

endpackage

// *** msac_link_if.sv ***
// Pin-level link between the converter chip and its sequencing controller
`timescale 1ns/1ns
interface msac_link_if;
    logic                     conv_clk;
    logic                     chan_strobe;
    logic                     mux_connect;
    logic                     start_conv;
    logic                     result_drive;
    logic                     channel_select_w8;
    logic                     channel_select_w4;
    logic                     channel_select_w2;
    logic                     channel_select_w1;
    logic                     conv_done;
    msac_pkg::msac_result_t   data_out;
    logic                     data_oe;
    msac_pkg::msac_result_t   data_bus;

    // Undriven three-state bus reads as pulled high
    assign data_bus = data_oe ? data_out : 8'hFF;

    modport dev (
        input  conv_clk, chan_strobe, mux_connect, start_conv, result_drive,
        input  channel_select_w8, channel_select_w4,
        input  channel_select_w2, channel_select_w1,
        output conv_done, data_out, data_oe
    );

    modport ctl (
        output conv_clk, chan_strobe, mux_connect, start_conv, result_drive,
        output channel_select_w8, channel_select_w4,
        output channel_select_w2, channel_select_w1,
        input  conv_done, data_bus
    );
endinterface

// *** msac_controller.sv ***
// Controller end: Wishbone registers, conversion clock, pin sequencing
`timescale 1ns/1ns
`include "msac_map.svh"
module msac_controller (
    input  wire logic         clk_i,     // System clock
    input  wire logic         rst_i,     // Sync reset, high
    msac_link_if.ctl          link,      // Pins to converter
    input  wire logic         wb_cyc_i,  // Wishbone cycle
    input  wire logic         wb_stb_i,  // Wishbone strobe
    input  wire logic         wb_we_i,   // Wishbone write
    input  wire logic [7:0]   wb_adr_i,  // Byte address
    input  wire logic [31:0]  wb_dat_i,  // Write data
    input  wire logic [3:0]   wb_sel_i,  // Byte lanes
    output logic [31:0]       wb_dat_o,  // Read data
    output logic              wb_ack_o,  // Acknowledge
    output logic              irq_o      // Level interrupt
);
    import msac_pkg::*;

    msac_ctl_state_t  state_reg;
    logic [15:0]      cnt_reg;
    logic [15:0]      div_reg;
    logic             ck_reg;
    logic [5:0]       ctrl_reg;
    logic             go_reg;
    logic             stat_reg;
    logic             stat_next;
    logic             mask_reg;
    logic             irq_reg;
    logic             ack_reg;
    logic [31:0]      dat_reg;
    msac_result_t     last_reg;
    logic             strobe_reg;
    logic             start_reg;
    logic             drive_reg;
    logic             done_meta_reg;
    logic             done_sync_reg;
    msac_result_t     bus_meta_reg;
    msac_result_t     bus_sync_reg;

    wire        bus_req  = wb_cyc_i & wb_stb_i;
    wire        wr_take  = bus_req & wb_we_i & ack_reg;
    wire        wr_ctrl  = wr_take && wb_adr_i == `MSAC_REG_CTRL;
    wire        wr_stat  = wr_take && wb_adr_i == `MSAC_REG_IRQ_STAT;
    wire        wr_mask  = wr_take && wb_adr_i == `MSAC_REG_IRQ_MASK;
    wire        busy     = (state_reg != CS_IDLE);
    wire        conv_end = (state_reg == CS_READ) &&
                           (cnt_reg == `MSAC_READ_WAIT);
    wire [31:0] rd_mux   =
        (wb_adr_i == `MSAC_REG_CTRL)     ? {26'h0, ctrl_reg} :
        (wb_adr_i == `MSAC_REG_STATUS)   ? {16'h0, last_reg, 6'h0,
                                            done_sync_reg, busy} :
        (wb_adr_i == `MSAC_REG_IRQ_STAT) ? {31'h0, stat_reg} :
        (wb_adr_i == `MSAC_REG_IRQ_MASK) ? {31'h0, mask_reg} : 32'h0;

    // Sticky event: a set in the clearing cycle wins
    assign stat_next = (stat_reg & ~(wr_stat & wb_sel_i[0] &
                        wb_dat_i[`MSAC_IRQ_DONE])) | conv_end;

    // Register slave and conversion clock divider
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg  <= 1'b0;
            dat_reg  <= 32'h0;
            ctrl_reg <= `MSAC_CTRL_RST;
            go_reg   <= 1'b0;
            stat_reg <= 1'b0;
            mask_reg <= `MSAC_MASK_RST;
            irq_reg  <= 1'b0;
            div_reg  <= 16'h0;
            ck_reg   <= 1'b0;
        end
        else
        begin
            ack_reg  <= bus_req & ~ack_reg;
            if (bus_req & ~ack_reg)
            begin
                dat_reg <= rd_mux;
            end
            if (wr_ctrl && wb_sel_i[0])
            begin
                ctrl_reg <= wb_dat_i[5:0];
            end
            go_reg   <= (wr_ctrl && wb_sel_i[1] && wb_dat_i[`MSAC_CTRL_GO])
                        | (go_reg & busy);
            stat_reg <= stat_next;
            if (wr_mask && wb_sel_i[0])
            begin
                mask_reg <= wb_dat_i[`MSAC_IRQ_DONE];
            end
            irq_reg  <= stat_next & mask_reg;
            div_reg  <= (div_reg == `MSAC_CONV_HALF - 16'h1) ? 16'h0
                        : div_reg + 16'h1;
            if (div_reg == `MSAC_CONV_HALF - 16'h1)
            begin
                ck_reg <= ~ck_reg;
            end
        end
    end

    // Pin sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg     <= CS_IDLE;
            cnt_reg       <= 16'h0;
            strobe_reg    <= 1'b0;
            start_reg     <= 1'b0;
            drive_reg     <= 1'b0;
            last_reg      <= 8'h00;
            done_meta_reg <= 1'b1;
            done_sync_reg <= 1'b1;
            bus_meta_reg  <= 8'h00;
            bus_sync_reg  <= 8'h00;
        end
        else
        begin
            done_meta_reg <= link.conv_done;
            done_sync_reg <= done_meta_reg;
            bus_meta_reg  <= link.data_bus;
            bus_sync_reg  <= bus_meta_reg;
            cnt_reg       <= cnt_reg + 16'h1;
            unique case (state_reg)
                CS_IDLE:
                begin
                    cnt_reg <= 16'h0;
                    if (go_reg)
                    begin
                        state_reg <= CS_SETUP;
                    end
                end
                CS_SETUP:
                begin
                    if (cnt_reg == 16'(`MSAC_ADDR_HOLD_CYC))
                    begin
                        strobe_reg <= 1'b1;
                        cnt_reg    <= 16'h0;
                        state_reg  <= CS_STROBE;
                    end
                end
                CS_STROBE:
                begin
                    if (cnt_reg == 16'(`MSAC_ADDR_HOLD_CYC))
                    begin
                        strobe_reg <= 1'b0;
                        start_reg  <= 1'b1;
                        state_reg  <= CS_START;
                    end
                end
                CS_START:
                begin
                    if (cnt_reg >= 16'(`MSAC_SETTLE_CYC) &&
                        cnt_reg >= 16'(`MSAC_START_CYC))
                    begin
                        start_reg <= 1'b0;
                        state_reg <= CS_LOW;
                    end
                end
                CS_LOW:
                begin
                    if (!done_sync_reg)
                    begin
                        state_reg <= CS_HIGH;
                    end
                end
                CS_HIGH:
                begin
                    cnt_reg <= 16'h0;
                    if (done_sync_reg)
                    begin
                        drive_reg <= 1'b1;
                        state_reg <= CS_READ;
                    end
                end
                CS_READ:
                begin
                    if (conv_end)
                    begin
                        last_reg  <= bus_sync_reg;
                        drive_reg <= 1'b0;
                        cnt_reg   <= 16'h0;
                        start_reg <= ctrl_reg[`MSAC_CTRL_FREE];
                        state_reg <= ctrl_reg[`MSAC_CTRL_FREE] ? CS_START
                                     : CS_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= CS_IDLE;
                end
            endcase
        end
    end

    assign link.conv_clk          = ck_reg;
    assign link.chan_strobe       = strobe_reg;
    assign link.mux_connect       = ctrl_reg[`MSAC_CTRL_MUX];
    assign link.start_conv        = start_reg;
    assign link.result_drive      = drive_reg;
    assign link.channel_select_w8 = ctrl_reg[3];
    assign link.channel_select_w4 = ctrl_reg[2];
    assign link.channel_select_w2 = ctrl_reg[1];
    assign link.channel_select_w1 = ctrl_reg[0];
    assign wb_dat_o               = dat_reg;
    assign wb_ack_o               = ack_reg;
    assign irq_o                  = irq_reg;

endmodule

// *** msac_link_props.sv ***
// Protocol checker for the pins between the converter and its controller
`timescale 1ns/1ns
module msac_link_props (
    input wire logic clk_i,             // System clock
    input wire logic rst_i,             // Sync reset
    input wire logic conv_clk,          // Conversion clock
    input wire logic chan_strobe,       // Channel latch strobe
    input wire logic start_conv,        // Conversion trigger
    input wire logic result_drive,      // Result drive request
    input wire logic channel_select_w8, // Select bit 3
    input wire logic channel_select_w4, // Select bit 2
    input wire logic channel_select_w2, // Select bit 1
    input wire logic channel_select_w1, // Select bit 0
    input wire logic conv_done,         // Conversion done
    input wire logic data_oe            // Result bus enable
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [3:0] sel;
    logic       clk_d_reg;
    logic       strobe_d_reg;
    logic [6:0] tick_reg;
    logic [6:0] tick_next;
    logic [9:0] high_reg;
    logic [9:0] high_next;
    logic [9:0] since_reg;
    logic [9:0] since_next;

    assign sel = {channel_select_w8, channel_select_w4,
                  channel_select_w2, channel_select_w1};
    // Conversion clock rises seen since the trigger last fell
    assign tick_next = start_conv ? 7'h00 : tick_reg
        + {6'h00, conv_clk & ~clk_d_reg & ~&tick_reg};
    assign high_next = start_conv ? high_reg + {9'h000, ~&high_reg} : 10'h000;
    assign since_next = (chan_strobe & ~strobe_d_reg) ? 10'h000
        : since_reg + {9'h000, ~&since_reg};

    always_ff @(posedge clk_i)
    begin
        clk_d_reg <= conv_clk;
        strobe_d_reg <= chan_strobe;
        tick_reg <= rst_i ? 7'h00 : tick_next;
        high_reg <= rst_i ? 10'h000 : high_next;
        since_reg <= rst_i ? 10'h000 : since_next;
    end

    property p_strobe_setup;
        $rose(chan_strobe) |-> sel == $past(sel, 5);
    endproperty
    a_strobe_setup: assert property (p_strobe_setup)
        else $error("select moved just before the strobe");
    property p_strobe_hold;
        $rose(chan_strobe) |=> $stable(sel) [*5];
    endproperty
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("select moved just after the strobe");
    property p_start_width;
        $fell(start_conv) |-> high_reg >= 10'd20;
    endproperty
    a_start_width: assert property (p_start_width)
        else $error("trigger pulse too short");
    property p_settle;
        $fell(start_conv) |-> since_reg >= 10'd250;
    endproperty
    a_settle: assert property (p_settle)
        else $error("trigger fell before the channel settled");
    property p_done_fall;
        $rose(start_conv) |-> ##[1:170] !conv_done;
    endproperty
    a_done_fall: assert property (p_done_fall)
        else $error("done did not fall after the trigger rose");
    property p_conv_len;
        // A clock rise level with the trigger fall counts here only
        $rose(conv_done) |-> tick_reg >= 7'd64 && tick_reg <= 7'd65;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length is not 64 clock periods");
    property p_oe_on;
        $rose(result_drive) |-> ##3 data_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("result bus not driven on request");
    property p_oe_off;
        !result_drive [*4] |-> !data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("result bus driven without request");
    property p_drive_done;
        $rose(result_drive) |-> conv_done;
    endproperty
    a_drive_done: assert property (p_drive_done)
        else $error("result read before done");
endmodule

// *** mux_sar_adc_control_tb_top.sv ***
// Testbench: controller and converter joined, driven over Wishbone
`timescale 1ns/1ns
`include "msac_map.svh"
module mux_sar_adc_control_tb_top;
    import msac_pkg::*;
    logic         clk_i;
    logic         rst_i;
    logic         cmp_i;
    logic         wb_cyc_i;
    logic         wb_stb_i;
    logic         wb_we_i;
    logic [7:0]   wb_adr_i;
    logic [31:0]  wb_dat_i;
    logic [3:0]   wb_sel_i;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic         irq_o;
    logic [15:0]  chan_on;
    msac_result_t dac_code;
    msac_result_t ain;
    msac_result_t bus_seen;
    logic [31:0]  seed;
    logic [31:0]  rd;
    logic [3:0]   ch;
    logic         mux_on;
    logic         mask;
    int           n_errors;
    int           n_tests;
    int           k;

    msac_link_if link ();
    msac_device i_msac_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .cmp_i(cmp_i), .channel_on_o(chan_on), .dac_code_o(dac_code));
    msac_controller i_msac_controller (.clk_i(clk_i), .rst_i(rst_i),
        .link(link), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o));
    msac_link_props i_msac_link_props (.clk_i(clk_i), .rst_i(rst_i),
        .conv_clk(link.conv_clk), .chan_strobe(link.chan_strobe),
        .start_conv(link.start_conv), .result_drive(link.result_drive),
        .channel_select_w8(link.channel_select_w8),
        .channel_select_w4(link.channel_select_w4),
        .channel_select_w2(link.channel_select_w2),
        .channel_select_w1(link.channel_select_w1),
        .conv_done(link.conv_done), .data_oe(link.data_oe));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask

    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'h0;
        forever
            #5 clk_i = ~clk_i;
    end

    // Comparator of an ideal input at level ain; result should equal ain
    always @(posedge clk_i)
    begin
        cmp_i <= (ain >= dac_code);
        if (link.data_oe === 1'h1)
            bus_seen <= link.data_bus;
    end

    initial
    begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end

    initial
    begin
        rst_i = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        ain = 8'h00;
        bus_seen = 8'h00;
        seed = 32'h65AD;
        n_errors = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, `MSAC_REG_CTRL, 32'h0);
        check(rd, 32'h10);
        wb(1'h0, `MSAC_REG_STATUS, 32'h0);
        check(rd, 32'h2);
        wb(1'h0, `MSAC_REG_IRQ_MASK, 32'h0);
        check(rd, 32'h0);
        wb(1'h1, 8'h10, 32'hFFFFFFFF);
        wb(1'h0, 8'h10, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            ch = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : seed[3:0];
            ain <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[15:8];
            mux_on = (i != 2);
            mask = (i != 1);
            wb(1'h1, `MSAC_REG_IRQ_MASK, {31'h0, mask});
            wb(1'h1, `MSAC_REG_CTRL, {24'h1, 3'h0, mux_on, ch});
            k = 0;
            do
            begin
                wb(1'h0, `MSAC_REG_IRQ_STAT, 32'h0);
                k++;
            end
            while (rd[0] !== 1'h1 && k < 8000);
            check(rd[0], 1'h1);
            check({link.channel_select_w8, link.channel_select_w4,
                   link.channel_select_w2, link.channel_select_w1}, ch);
            wb(1'h0, `MSAC_REG_STATUS, 32'h0);
            check(rd[15:8], ain);
            check(bus_seen, ain);
            check(link.data_bus, 8'hFF);
            check(chan_on, mux_on ? 16'h1 << ch : 16'h0);
            check(irq_o, mask);
            wb(1'h1, `MSAC_REG_IRQ_MASK, 32'h1);
            repeat (2) @(posedge clk_i);
            check(irq_o, 1'h1);
            wb(1'h1, `MSAC_REG_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk_i);
            check(irq_o, 1'h0);
            wb(1'h0, `MSAC_REG_IRQ_STAT, 32'h0);
            check(rd, 32'h0);
        end
        // Free-running: one GO, then the controller re-triggers by itself
        seed = lfsr(seed);
        ain <= seed[23:16];
        wb(1'h1, `MSAC_REG_CTRL, 32'h13A);
        for (int j = 0; j < 2; j++)
        begin
            k = 0;
            do
            begin
                wb(1'h0, `MSAC_REG_IRQ_STAT, 32'h0);
                k++;
            end
            while (rd[0] !== 1'h1 && k < 8000);
            check(rd[0], 1'h1);
            wb(1'h0, `MSAC_REG_STATUS, 32'h0);
            check(rd[15:8], ain);
            wb(1'h1, `MSAC_REG_CTRL, 32'h1A);
            wb(1'h1, `MSAC_REG_IRQ_STAT, 32'h1);
        end
        wb(1'h0, `MSAC_REG_STATUS, 32'h0);
        check(rd[1:0], 2'h2);
        complete_run();
    end
endmodule
